// >>> nwdt_pkg.sv
// Constants shared by the watchdog end and the CPU-side end.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
package nwdt_pkg;

  // ----------------------------------------
  // Clocking and timing
  // ----------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int TICK_HZ         = 256;
  localparam int TICK_CYCLES_DEF = CLK_HZ / TICK_HZ;
  localparam int PRE_W           = $clog2(TICK_CYCLES_DEF);
  localparam int CNT_W           = 10;

  // ----------------------------------------
  // Watchdog I/O register
  // ----------------------------------------
  localparam int              IO_ADDR_W    = 16;
  localparam int              IO_DATA_W    = 4;
  localparam logic [15:0]     WDCTL_ADDR   = 16'hff07;
  localparam int              BIT_CLEAR    = 0;
  localparam int              BIT_ENABLE   = 1;
  localparam logic            ENABLE_RESET = 1'b1;

  // ----------------------------------------
  // CPU side
  // ----------------------------------------
  localparam int          PC_W       = 16;
  localparam logic [15:0] NMI_VECTOR = 16'h0100;

  // ----------------------------------------
  // AXI4-Lite map of the CPU-side end
  // ----------------------------------------
  localparam int          AXI_ADDR_W = 8;
  localparam logic [7:0]  OFS_WDCTL  = 8'h00;
  localparam logic [7:0]  OFS_CPU    = 8'h04;
  localparam logic [7:0]  OFS_SP     = 8'h08;
  localparam logic [7:0]  OFS_STAT   = 8'h0c;
  localparam logic [7:0]  OFS_MASK   = 8'h10;
  localparam logic [7:0]  OFS_PC     = 8'h14;
  localparam int          BIT_IEN    = 0;
  localparam int          BIT_HALT   = 1;
  localparam int          BIT_SP1    = 0;
  localparam int          BIT_SP2    = 1;
  localparam int          ST_W       = 2;
  localparam int          ST_REQ     = 0;
  localparam int          ST_TAKEN   = 1;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    NWDT_REG_WDCTL = 3'b000,
    NWDT_REG_CPU   = 3'b001,
    NWDT_REG_SP    = 3'b010,
    NWDT_REG_STAT  = 3'b011,
    NWDT_REG_MASK  = 3'b100,
    NWDT_REG_PC    = 3'b101,
    NWDT_REG_NONE  = 3'b111
  } nwdt_reg_t;

  typedef enum logic [1:0] {
    NWDT_RD_IDLE  = 2'b00,
    NWDT_RD_ISSUE = 2'b01,
    NWDT_RD_WAIT  = 2'b10,
    NWDT_RD_RESP  = 2'b11
  } nwdt_rd_t;

endpackage

// >>> nwdt_if.sv
// I/O-register port and NMI request between watchdog and CPU end.
// Assumes both ends share one clock; no clocking block is used.
`timescale 1ns/1ps
`default_nettype none
interface nwdt_if;
  logic [15:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [3:0]  io_wdata;
  logic [3:0]  io_rdata;
  logic        nmi_req;

  modport watchdog (
    input  io_addr, io_wr, io_rd, io_wdata,
    output io_rdata, nmi_req
  );

  modport cpu (
    output io_addr, io_wr, io_rd, io_wdata,
    input  io_rdata, nmi_req
  );
endinterface
`default_nettype wire

// >>> nwdt_watchdog.sv
// Watchdog end: 256 Hz tick, 10-bit chain, control register, NMI pulse.
// Assumes the CPU end drives io_wr/io_rd as one-cycle strobes.
//
// Functional notes
// - Count chain advanced by divided 256 Hz tick
// - 10-bit chain; overflow raises NMI request
// - Uncleared running watchdog interrupts after ~4 s
// - Counting continues while CPU is halted
// - CPU accepts NMI regardless of interrupt flag
// - CPU holds NMI until stack halves paired
// - CPU vectors accepted NMI to 0100H
// - Enable bit D1: one counts, zero stops
// - Enable bit is one after reset
// - Writing one to D0 zeroes counter
// - Clear bit always reads zero
// - Bits D3, D2 ignore writes, read zero
// - Software clears at most every 3 s
// - Unused watchdog disabled soon after reset
`timescale 1ns/1ps
`default_nettype none
module nwdt_watchdog #(
  parameter int TICK_CYCLES = nwdt_pkg::TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // CPU end
  nwdt_if.watchdog                         bus,
  // Observation
  output logic [nwdt_pkg::CNT_W-1:0]       watchdog_count,
  output logic                             watchdog_run_enable
);

  // ----------------------------------------
  // Tick divider
  // ----------------------------------------
  // Free-running so a clear does not restart the tick phase; this is
  // why the timeout lands anywhere within one tick below 4 s.
  logic [nwdt_pkg::PRE_W-1:0] pre;
  logic                       tick;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre  <= '0;
      tick <= 1'b0;
    end else if (pre == nwdt_pkg::PRE_W'(TICK_CYCLES - 1)) begin
      pre  <= '0;
      tick <= 1'b1;
    end else begin
      pre  <= pre + 1'b1;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  logic wr_hit;
  logic rd_hit;
  logic clear_req;

  assign wr_hit    = bus.io_wr && (bus.io_addr == nwdt_pkg::WDCTL_ADDR);
  assign rd_hit    = bus.io_rd && (bus.io_addr == nwdt_pkg::WDCTL_ADDR);
  assign clear_req = wr_hit && bus.io_wdata[nwdt_pkg::BIT_CLEAR];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_run_enable <= nwdt_pkg::ENABLE_RESET;
    end else if (wr_hit) begin
      watchdog_run_enable <= bus.io_wdata[nwdt_pkg::BIT_ENABLE];
    end
  end

  // ----------------------------------------
  // Count chain and NMI
  // ----------------------------------------
  // No halt input: the chain keeps running while the CPU is halted.
  logic last;

  assign last = &watchdog_count;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_count <= '0;
    end else if (clear_req) begin
      watchdog_count <= '0;
    end else if (watchdog_run_enable && tick) begin
      watchdog_count <= watchdog_count + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus.nmi_req <= 1'b0;
    end else begin
      // A clear in the overflow cycle wins; stopped chain never fires.
      bus.nmi_req <= watchdog_run_enable && tick && last
                     && !clear_req;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus.io_rdata <= '0;
    end else if (rd_hit) begin
      bus.io_rdata <= '0;
      bus.io_rdata[nwdt_pkg::BIT_ENABLE] <= watchdog_run_enable;
    end else begin
      bus.io_rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// >>> nwdt_cpu.sv
// CPU end: AXI4-Lite command registers, I/O strobes, NMI acceptance.
// Assumes an AXI4-Lite master on the same clock as the watchdog.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module nwdt_cpu (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // Watchdog end
  nwdt_if.cpu                          wd,
  // AXI4-Lite write
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // CPU state
  output logic                         irq,
  output logic                         nmi_taken,
  output logic [nwdt_pkg::PC_W-1:0]    nmi_vector_pc,
  output logic                         cpu_halted
);

  function automatic nwdt_pkg::nwdt_reg_t dec(input logic [7:0] a);
    if (a == nwdt_pkg::OFS_WDCTL) begin
      dec = nwdt_pkg::NWDT_REG_WDCTL;
    end else if (a == nwdt_pkg::OFS_CPU) begin
      dec = nwdt_pkg::NWDT_REG_CPU;
    end else if (a == nwdt_pkg::OFS_SP) begin
      dec = nwdt_pkg::NWDT_REG_SP;
    end else if (a == nwdt_pkg::OFS_STAT) begin
      dec = nwdt_pkg::NWDT_REG_STAT;
    end else if (a == nwdt_pkg::OFS_MASK) begin
      dec = nwdt_pkg::NWDT_REG_MASK;
    end else if (a == nwdt_pkg::OFS_PC) begin
      dec = nwdt_pkg::NWDT_REG_PC;
    end else begin
      dec = nwdt_pkg::NWDT_REG_NONE;
    end
  endfunction

  // ----------------------------------------
  // Write channel capture
  // ----------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        w_lane0;
  logic        wr_go;
  nwdt_pkg::nwdt_reg_t wr_reg;

  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign wr_reg = dec(aw_addr);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_lane0      <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_lane0      <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= nwdt_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_reg == nwdt_pkg::NWDT_REG_NONE)
                      ? nwdt_pkg::RESP_SLVERR : nwdt_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wr_en;
  assign wr_en = wr_go && w_lane0;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  nwdt_pkg::nwdt_rd_t rd_state;
  logic [7:0]          ar_addr;
  logic                rd_io;

  // Strobe at the address handshake: the watchdog answers one edge later,
  // so its data stands when the WAIT state captures it.
  assign rd_io = (rd_state == nwdt_pkg::NWDT_RD_IDLE) && s_axi_arvalid;

  // ----------------------------------------
  // I/O strobes to the watchdog
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wd.io_wr    <= 1'b0;
      wd.io_rd    <= 1'b0;
      wd.io_addr  <= '0;
      wd.io_wdata <= '0;
    end else begin
      wd.io_wr    <= wr_en && (wr_reg == nwdt_pkg::NWDT_REG_WDCTL);
      wd.io_rd    <= rd_io;
      wd.io_addr  <= nwdt_pkg::WDCTL_ADDR;
      wd.io_wdata <= w_data[nwdt_pkg::IO_DATA_W-1:0];
    end
  end

  // ----------------------------------------
  // CPU control, stack-pointer pairing
  // ----------------------------------------
  logic int_enable;
  logic sp_masked;
  logic sp_first_seen;
  logic pend;
  logic accept;

  assign accept = pend && !sp_masked;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_enable <= 1'b0;
      cpu_halted <= 1'b0;
    end else begin
      if (wr_en && wr_reg == nwdt_pkg::NWDT_REG_CPU) begin
        int_enable <= w_data[nwdt_pkg::BIT_IEN];
      end
      // The NMI ends a halt; it wins over a halt write in the same cycle.
      if (accept) begin
        cpu_halted <= 1'b0;
      end else if (wr_en && wr_reg == nwdt_pkg::NWDT_REG_CPU
                   && w_data[nwdt_pkg::BIT_HALT]) begin
        cpu_halted <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_masked     <= 1'b1;
      sp_first_seen <= 1'b0;
    end else if (wr_en && wr_reg == nwdt_pkg::NWDT_REG_SP) begin
      if (w_data[nwdt_pkg::BIT_SP1]) begin
        sp_masked     <= 1'b1;
        sp_first_seen <= 1'b1;
      end else if (w_data[nwdt_pkg::BIT_SP2] && sp_first_seen) begin
        sp_masked     <= 1'b0;
        sp_first_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // NMI acceptance
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend <= 1'b0;
    end else if (wd.nmi_req) begin
      pend <= 1'b1;
    end else if (accept) begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmi_taken     <= 1'b0;
      nmi_vector_pc <= '0;
    end else begin
      nmi_taken <= accept;
      if (accept) begin
        nmi_vector_pc <= nwdt_pkg::NMI_VECTOR;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  logic [nwdt_pkg::ST_W-1:0] status;
  logic [nwdt_pkg::ST_W-1:0] mask;
  logic [nwdt_pkg::ST_W-1:0] st_set;
  logic [nwdt_pkg::ST_W-1:0] st_clr;

  assign st_set = {accept, wd.nmi_req};
  assign st_clr = (wr_en && wr_reg == nwdt_pkg::NWDT_REG_STAT)
                  ? w_data[nwdt_pkg::ST_W-1:0] : '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
    end else begin
      // Set beats a simultaneous write-one clear
      status <= (status & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask <= '0;
    end else if (wr_en && wr_reg == nwdt_pkg::NWDT_REG_MASK) begin
      mask <= w_data[nwdt_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ----------------------------------------
  // Read state machine
  // ----------------------------------------
  // Every read takes two edges after the handshake, mapped or not.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_state      <= nwdt_pkg::NWDT_RD_IDLE;
      ar_addr       <= '0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= nwdt_pkg::RESP_OKAY;
    end else begin
      case (rd_state)
        nwdt_pkg::NWDT_RD_IDLE: begin
          if (s_axi_arvalid) begin
            ar_addr       <= s_axi_araddr;
            s_axi_arready <= 1'b0;
            rd_state      <= nwdt_pkg::NWDT_RD_ISSUE;
          end
        end
        nwdt_pkg::NWDT_RD_ISSUE: begin
          rd_state <= nwdt_pkg::NWDT_RD_WAIT;
        end
        nwdt_pkg::NWDT_RD_WAIT: begin
          s_axi_rvalid <= 1'b1;
          s_axi_rresp  <= nwdt_pkg::RESP_OKAY;
          s_axi_rdata  <= '0;
          rd_state     <= nwdt_pkg::NWDT_RD_RESP;
          case (dec(ar_addr))
            nwdt_pkg::NWDT_REG_WDCTL: begin
              s_axi_rdata[nwdt_pkg::IO_DATA_W-1:0] <= wd.io_rdata;
            end
            nwdt_pkg::NWDT_REG_CPU: begin
              s_axi_rdata[nwdt_pkg::BIT_IEN]  <= int_enable;
              s_axi_rdata[nwdt_pkg::BIT_HALT] <= cpu_halted;
            end
            nwdt_pkg::NWDT_REG_SP: begin
              s_axi_rdata[nwdt_pkg::BIT_SP1] <= sp_masked;
              s_axi_rdata[nwdt_pkg::BIT_SP2] <= sp_first_seen;
            end
            nwdt_pkg::NWDT_REG_STAT: begin
              s_axi_rdata[nwdt_pkg::ST_W-1:0] <= status;
            end
            nwdt_pkg::NWDT_REG_MASK: begin
              s_axi_rdata[nwdt_pkg::ST_W-1:0] <= mask;
            end
            nwdt_pkg::NWDT_REG_PC: begin
              s_axi_rdata[nwdt_pkg::PC_W-1:0] <= nmi_vector_pc;
            end
            default: begin
              s_axi_rresp <= nwdt_pkg::RESP_SLVERR;
            end
          endcase
        end
        default: begin
          if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state      <= nwdt_pkg::NWDT_RD_IDLE;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> nwdt_properties.sv
// Concurrent checks on the watchdog link and the count chain.
// Assumes one clock; the bench instantiates it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module nwdt_properties #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Link
  input wire logic [15:0] io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [3:0]  io_wdata,
  input wire logic [3:0]  io_rdata,
  input wire logic        nmi_req,
  // Watchdog state
  input wire logic [9:0]  watchdog_count,
  input wire logic        watchdog_run_enable
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [31:0] phase;
  logic        wr_hit;
  logic        rd_hit;
  logic        clr_hit;
  assign wr_hit = io_wr && io_addr == nwdt_pkg::WDCTL_ADDR;
  assign rd_hit = io_rd && io_addr == nwdt_pkg::WDCTL_ADDR;
  assign clr_hit = wr_hit && io_wdata[nwdt_pkg::BIT_CLEAR];
  // Mirrors the free-running divider, so ticks land on phase wrap
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      phase <= 32'h0;
    else
      phase <= (phase == TICK_CYCLES - 1) ? 32'h0 : phase + 32'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_nmi_one_cycle: assert property (
    nmi_req |=> !nmi_req) else $error("nmi request too long");
  chk_nmi_at_wrap: assert property (
    nmi_req |-> watchdog_count == 10'h0
      && $past(watchdog_count) == 10'h3ff) else $error("stray nmi");
  chk_wrap_gives_nmi: assert property (
    $past(watchdog_count) == 10'h3ff && watchdog_count == 10'h0
      && !$past(clr_hit) |-> nmi_req) else $error("wrap without nmi");
  chk_count_step: assert property (
    watchdog_count != $past(watchdog_count) |-> watchdog_count == 10'h0
      || watchdog_count == $past(watchdog_count) + 10'h1)
    else $error("count jumped");
  chk_tick_phase: assert property (
    watchdog_count == $past(watchdog_count) + 10'h1 && !$past(clr_hit)
      |-> $past(phase, 2) == TICK_CYCLES - 1) else $error("count off tick");
  chk_hold_disabled: assert property (
    !$past(watchdog_run_enable) |-> $stable(watchdog_count)
      || watchdog_count == 10'h0) else $error("count ran disabled");
  chk_no_nmi_off: assert property (
    !$past(watchdog_run_enable) |-> !nmi_req)
    else $error("nmi while disabled");
  chk_clear_zeroes: assert property (
    clr_hit |=> watchdog_count == 10'h0) else $error("clear missed");
  chk_enable_write: assert property (
    wr_hit |=> watchdog_run_enable == $past(io_wdata[1]))
    else $error("enable write lost");
  chk_read_value: assert property (
    rd_hit && !io_wr |=> io_rdata == {2'h0, $past(watchdog_run_enable),
      1'h0}) else $error("bad read data");
  chk_reset_state: assert property (
    !$past(rstn) |-> watchdog_run_enable && watchdog_count == 10'h0)
    else $error("bad reset state");
endmodule
`default_nettype wire

// >>> nmi_watchdog_timer_tb_top.sv
// Bench: both ends joined by the interface, AXI4-Lite stimulus.
// Assumes package, interface, both ends and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module nmi_watchdog_timer_tb_top;
  localparam int TICK = 4;
  logic        clk;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h0;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h0;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        irq;
  logic        nmi_taken;
  logic [15:0] pc;
  logic        halted;
  logic [9:0]  count;
  logic        wd_en;
  int          n_fail;
  int          n_compared;
  int          n_nmi;
  int          n_req;
  int          cyc;
  int          c0;
  // ----------------------------------------
  // Structure
  // ----------------------------------------
  nwdt_if nwdt_if_i ();
  nwdt_watchdog #(.TICK_CYCLES(TICK)) nwdt_watchdog_i (
    .clk(clk), .rstn(rstn), .bus(nwdt_if_i),
    .watchdog_count(count), .watchdog_run_enable(wd_en));
  nwdt_cpu nwdt_cpu_i (
    .clk(clk), .rstn(rstn), .wd(nwdt_if_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq), .nmi_taken(nmi_taken),
    .nmi_vector_pc(pc), .cpu_halted(halted));
  nwdt_properties #(.TICK_CYCLES(TICK)) nwdt_properties_i (
    .clk(clk), .rstn(rstn), .io_addr(nwdt_if_i.io_addr),
    .io_wr(nwdt_if_i.io_wr), .io_rd(nwdt_if_i.io_rd),
    .io_wdata(nwdt_if_i.io_wdata), .io_rdata(nwdt_if_i.io_rdata),
    .nmi_req(nwdt_if_i.nmi_req), .watchdog_count(count),
    .watchdog_run_enable(wd_en));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Event counters and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (nmi_taken === 1'b1) n_nmi <= n_nmi + 1;
    if (nwdt_if_i.nmi_req === 1'b1) n_req <= n_req + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      $display("mismatch t=%0t timeout", $time);
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er, "bresp");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e, "rdata");
    chk(rresp, er, "rresp");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, nwdt_pkg::RESP_OKAY);
  endtask
  task automatic wait_until_nmi(input int n0, output int k);
    k = 0;
    while (n_nmi == n0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic t_reset();
    chk(wd_en, 1'b1, "enable after reset");
    rd_chk(nwdt_pkg::OFS_WDCTL, 32'h2, nwdt_pkg::RESP_OKAY);
    axi_wr(8'h20, 32'h3, nwdt_pkg::RESP_SLVERR);
    rd_chk(8'h20, 32'h0, nwdt_pkg::RESP_SLVERR);
  endtask
  // Reset leaves the CPU stack-masked, so the first NMI must wait
  task automatic t_pairing();
    int k;
    k = 0;
    while (n_req == 0 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    chk(cyc - c0 >= 4094 && cyc - c0 <= 4102, 1'b1, "first wrap");
    repeat (8) @(posedge clk);
    chk(n_nmi, 0, "nmi before pairing");
    wr(nwdt_pkg::OFS_SP, 32'h1);
    wr(nwdt_pkg::OFS_SP, 32'h2);
    repeat (8) @(posedge clk);
    chk(n_nmi, 1, "pending nmi taken");
    chk(pc, nwdt_pkg::NMI_VECTOR, "vector");
    rd_chk(nwdt_pkg::OFS_STAT, 32'h3, nwdt_pkg::RESP_OKAY);
  endtask
  task automatic t_halt();
    int k;
    wr(nwdt_pkg::OFS_STAT, 32'h3);
    wr(nwdt_pkg::OFS_MASK, 32'h0);
    wr(nwdt_pkg::OFS_CPU, 32'h2);
    repeat (2) @(posedge clk);
    chk(halted, 1'b1, "halt entered");
    wr(nwdt_pkg::OFS_WDCTL, 32'h3);
    wait_until_nmi(n_nmi, k);
    chk(k >= 4090 && k <= 4104, 1'b1, "nmi delay");
    chk(halted, 1'b0, "halt released");
    chk(irq, 1'b0, "irq masked");
    wr(nwdt_pkg::OFS_MASK, 32'h2);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1, "irq raised");
    wr(nwdt_pkg::OFS_STAT, 32'h3);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0, "irq cleared");
  endtask
  task automatic t_fields();
    wr(nwdt_pkg::OFS_WDCTL, 32'hd);
    rd_chk(nwdt_pkg::OFS_WDCTL, 32'h0, nwdt_pkg::RESP_OKAY);
    repeat (40) @(posedge clk);
    chk(count, 10'h0, "count held");
    wr(nwdt_pkg::OFS_WDCTL, 32'h2);
    repeat (40) @(posedge clk);
    chk(count != 10'h0, 1'b1, "count runs");
  endtask
  task automatic t_feed_and_stop();
    int n0;
    n0 = n_req;
    repeat (3) begin
      wr(nwdt_pkg::OFS_WDCTL, 32'h3);
      repeat (3500) @(posedge clk);
    end
    chk(n_req, n0, "fed watchdog fired");
    wr(nwdt_pkg::OFS_WDCTL, 32'h0);
    repeat (5000) @(posedge clk);
    chk(n_req, n0, "disabled watchdog fired");
  endtask
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    c0 = cyc;
    t_reset();
    t_pairing();
    t_halt();
    t_fields();
    t_feed_and_stop();
    report_and_stop();
  end
endmodule
`default_nettype wire
